//--- include/msr_pkg.sv
/*
 Constants, state codes and shared helpers for the motor start-up and
 reverse sequencer. Assumes one 40 MHz system clock and a synchronous reset.
 // Function
 //- Reverse only with detection, enable, opposite spin
 //- Lock, decelerate through zero, accelerate commanded way
 //- Select reverse or forward parameter set
 //- Enter reverse open loop at entry speed
 //- Reverse open loop uses reverse current limit
 //- Reversal acceleration from reverse coefficients
 //- Deceleration is percent of reverse acceleration
 //- Decode two-bit start-up method field
 //- Align holds pattern for time, limited
 //- Align current ramps up from zero
 //- Second align leads first by 90 degrees
 //- Probe six patterns BC CB AB BA CA AC
 //- Stop pattern at threshold, record rise time
 //- Shortest rise time gives rotor position
 //- Release recirculates via low side or floats
 //- Open loop starts at position plus advance
 //- First cycle at slow rate, then profile
 //- Open loop with fixed limit, loops on
 //- Open loop limit from global or dedicated
 //- Open loop speed from two coefficients
 //- Stay closed loop while reverse speed exceeds threshold
 //- Closed loop entry automatic or configured speed
*/
package msr_pkg;
	// Clock and control tick
	localparam int CLK_PERIOD_NS = 25;
	localparam int CTRL_TICK_NS = 10_000;
	localparam int TICK_CYCLES = CTRL_TICK_NS / CLK_PERIOD_NS;
	// Widths
	localparam int SPEED_W = 16;
	localparam int ANGLE_W = 16;
	localparam int CURR_W = 12;
	localparam int TIME_W = 16;
	localparam int PROBE_LAST = 5;
	localparam int PERCENT_FULL = 100;
	// Start-up method codes
	localparam logic [1:0] START_ALIGN = 2'h0;
	localparam logic [1:0] START_DOUBLE = 2'h1;
	localparam logic [1:0] START_PROBE = 2'h2;
	localparam logic [1:0] START_SLOW = 2'h3;
	// Angles, full turn is 2^16
	localparam logic [ANGLE_W-1:0] ANGLE_90 = 16'h4000;
	// Gates {hs_a, ls_a, hs_b, ls_b, hs_c, ls_c}
	localparam logic [5:0] LOW_SIDE_MASK = 6'h15;
	localparam logic [5:0] GATES_OFF = 6'h00;

	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_WAIT_DETECT = 4'h1,
		ST_REV_CL = 4'h2,
		ST_REV_OL = 4'h3,
		ST_ALIGN1 = 4'h4,
		ST_ALIGN2 = 4'h5,
		ST_PROBE_DRIVE = 4'h6,
		ST_PROBE_RELEASE = 4'h7,
		ST_SLOW = 4'h8,
		ST_OPEN_LOOP = 4'h9,
		ST_CLOSED_LOOP = 4'hA
	} msr_state_type;

	// Probe pattern index to switch gates, order BC CB AB BA CA AC
	function automatic logic [5:0] probe_gates(input logic [2:0] idx);
		unique case (idx)
			3'h0: probe_gates = 6'h09;
			3'h1: probe_gates = 6'h06;
			3'h2: probe_gates = 6'h24;
			3'h3: probe_gates = 6'h18;
			3'h4: probe_gates = 6'h12;
			default: probe_gates = 6'h21;
		endcase
	endfunction

	// Electrical angle of each probe current vector
	function automatic logic [ANGLE_W-1:0] probe_angle(input logic [2:0] idx);
		unique case (idx)
			3'h0: probe_angle = 16'h4000;
			3'h1: probe_angle = 16'hC000;
			3'h2: probe_angle = 16'h1555;
			3'h3: probe_angle = 16'h6AAB;
			3'h4: probe_angle = 16'h9555;
			default: probe_angle = 16'hEAAB;
		endcase
	endfunction

	// Ramp generator angle step in the drive direction
	function automatic logic [ANGLE_W-1:0] adv_angle(input logic [ANGLE_W-1:0] a,
		input logic [SPEED_W-1:0] s, input logic fwd);
		adv_angle = fwd ? a + ANGLE_W'(s) : a - ANGLE_W'(s);
	endfunction
endpackage

//--- core/msr_ramp.sv
/*
 Open-loop speed ramp: quadratic acceleration and percentage deceleration.
 Assumes tick is a one-cycle enable from the sequencer's control divider.
*/
`timescale 1ns/100ps
module msr_ramp import msr_pkg::*; #(
	parameter int W = SPEED_W
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Control
	input wire logic tick,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	input wire logic up,
	// Coefficients
	input wire logic [W-1:0] a1,
	input wire logic [W-1:0] a2,
	input wire logic [7:0] dec_pct,
	// Speed
	output logic [W-1:0] speed_q
);
	localparam int XW = 2 * W + 3;
	localparam logic [XW-1:0] S2_MAX = XW'({(W + 1){1'b1}});
	logic [W:0] s2_q;
	logic [W:0] s2_d;
	logic [W-1:0] n_q;
	logic [W-1:0] n_d;
	logic [XW-1:0] inc;
	logic [XW-1:0] sum;
	logic [XW-1:0] dec;

	// Doubled speed keeps the half of a2 exact: steps are 2a1 + a2(2n+1)
	always_comb begin
		inc = XW'(a1) * XW'(2) + XW'(a2) * (XW'(n_q) * XW'(2) + XW'(1));
		sum = XW'(s2_q) + inc;
		dec = XW'(a1) * XW'(dec_pct) / XW'(PERCENT_FULL) * XW'(2);
		s2_d = s2_q;
		n_d = n_q;
		if (load) begin
			s2_d = {load_val, 1'b0};
			n_d = '0;
		end else if (tick && up) begin
			s2_d = (sum > S2_MAX) ? S2_MAX[W:0] : sum[W:0];
			n_d = (&n_q) ? n_q : n_q + 1'b1;
		end else if (tick) begin
			s2_d = (XW'(s2_q) > dec) ? s2_q - dec[W:0] : '0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			s2_q <= '0;
			n_q <= '0;
		end else begin
			s2_q <= s2_d;
			n_q <= n_d;
		end
	end

	assign speed_q = s2_q[W:1];

	chk_decel_no_wrap: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(tick && !up && !load) |=> (s2_q <= $past(s2_q)))
		else $error("ramp deceleration raised speed");
	chk_accel_step: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(tick && up && !load && sum <= S2_MAX) |=> (XW'(s2_q) == $past(sum)))
		else $error("ramp step differs from quadratic profile");
endmodule

//--- core/msr_probe_min.sv
/*
 Keeps the probe pattern with the shortest current rise time.
 Assumes rec pulses once per pattern, after clear at the start of probing.
*/
`timescale 1ns/100ps
module msr_probe_min import msr_pkg::*; #(
	parameter int TW = TIME_W
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Measurements
	input wire logic clear,
	input wire logic rec,
	input wire logic [2:0] idx,
	input wire logic [TW-1:0] rise_time,
	// Result
	output logic [2:0] min_idx_q
);
	logic [TW-1:0] min_time_q;
	logic [TW-1:0] min_time_d;
	logic [2:0] min_idx_d;

	// Strict compare keeps the earlier pattern on a tie
	always_comb begin
		min_time_d = min_time_q;
		min_idx_d = min_idx_q;
		if (clear) begin
			min_time_d = '1;
			min_idx_d = '0;
		end else if (rec && rise_time < min_time_q) begin
			min_time_d = rise_time;
			min_idx_d = idx;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			min_time_q <= '1;
			min_idx_q <= '0;
		end else begin
			min_time_q <= min_time_d;
			min_idx_q <= min_idx_d;
		end
	end

	chk_min_tracks: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(!clear && rec && rise_time < min_time_q) |=> (min_idx_q == $past(idx)))
		else $error("shorter rise time not taken as position");
endmodule

//--- core/msr_sequencer.sv
/*
 Start-up and reverse drive sequencer: detection hand-off, reverse
 deceleration, align, double align, inductive probing, slow first cycle,
 open-loop acceleration and closed-loop hand-off.
 Assumes phase current and speed estimates come from logic on clk_sys.
*/
`timescale 1ns/100ps
module msr_sequencer import msr_pkg::*; #(
	parameter int TICKS = TICK_CYCLES
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Command
	input wire logic start_req,
	input wire logic stop_req,
	input wire logic dir_cmd,
	// Initial speed detection result
	input wire logic initial_speed_detect_enable,
	input wire logic detect_done,
	input wire logic detect_opposite,
	input wire logic [SPEED_W-1:0] detect_speed,
	// Reverse drive configuration
	input wire logic reverse_drive_enable,
	input wire logic reverse_param_select,
	input wire logic [SPEED_W-1:0] reverse_openloop_entry_speed,
	input wire logic [CURR_W-1:0] reverse_openloop_current_limit,
	input wire logic [SPEED_W-1:0] reverse_accel_linear,
	input wire logic [SPEED_W-1:0] reverse_accel_quadratic,
	input wire logic [7:0] reverse_decel_percent,
	// Start-up configuration
	input wire logic [1:0] startup_method,
	input wire logic [ANGLE_W-1:0] align_angle,
	input wire logic [TIME_W-1:0] align_time,
	input wire logic [CURR_W-1:0] align_current_limit,
	input wire logic [CURR_W-1:0] align_ramp_rate,
	input wire logic [CURR_W-1:0] probe_current_threshold,
	input wire logic probe_release_select,
	input wire logic [TIME_W-1:0] probe_pattern_rate,
	input wire logic [ANGLE_W-1:0] probe_drive_advance,
	input wire logic [ANGLE_W-1:0] slow_cycle_step,
	// Open loop configuration
	input wire logic openloop_limit_source,
	input wire logic [CURR_W-1:0] global_current_limit,
	input wire logic [CURR_W-1:0] openloop_current_limit,
	input wire logic [SPEED_W-1:0] openloop_accel_linear,
	input wire logic [SPEED_W-1:0] openloop_accel_quadratic,
	input wire logic [SPEED_W-1:0] closed_loop_entry_speed,
	input wire logic auto_handoff_enable,
	input wire logic [SPEED_W-1:0] auto_handoff_speed,
	// Measurements
	input wire logic [CURR_W-1:0] phase_current,
	input wire logic [SPEED_W-1:0] est_speed,
	// Drive outputs
	output msr_state_type state_q,
	output logic drive_dir_q,
	output logic [SPEED_W-1:0] speed_ref_q,
	output logic [ANGLE_W-1:0] angle_q,
	output logic [CURR_W-1:0] current_limit_q,
	output logic [5:0] gates_q,
	output logic current_loops_on_q,
	output logic closed_loop_q,
	output logic [2:0] probe_position_q
);
	localparam int TICK_W = $clog2(TICKS);
	localparam logic [TIME_W-1:0] TIME_MAX = '1;

	msr_state_type state_d;
	logic [TICK_W-1:0] tick_cnt_q;
	logic [TICK_W-1:0] tick_cnt_d;
	logic tick_q;
	logic tick_d;
	logic drive_dir_d;
	logic [ANGLE_W-1:0] angle_d;
	logic [CURR_W-1:0] current_limit_d;
	logic [5:0] gates_d;
	logic [TIME_W-1:0] timer_q;
	logic [TIME_W-1:0] timer_d;
	logic [2:0] pidx_q;
	logic [2:0] pidx_d;
	logic rev_path_q;
	logic rev_path_d;
	logic current_loops_on_d;
	logic closed_loop_d;
	logic ramp_load;
	logic [SPEED_W-1:0] ramp_load_val;
	logic ramp_up;
	logic ramp_run;
	logic probe_clear;
	logic probe_rec;
	logic go_start;
	logic go_open;
	logic use_rev;
	logic [SPEED_W-1:0] rev_thr;
	logic [SPEED_W-1:0] handoff_speed;
	logic [CURR_W-1:0] ol_lim_fwd;
	logic [CURR_W-1:0] ol_lim_rev;
	logic [SPEED_W-1:0] ramp_a1;
	logic [SPEED_W-1:0] ramp_a2;
	logic [CURR_W:0] ilim_sum;
	logic [ANGLE_W:0] slow_sum;

	// Parameter set selection, shared by several states
	assign use_rev = rev_path_q && reverse_param_select;
	assign rev_thr = reverse_param_select ? reverse_openloop_entry_speed : closed_loop_entry_speed;
	assign handoff_speed = auto_handoff_enable ? auto_handoff_speed : closed_loop_entry_speed;
	assign ol_lim_fwd = openloop_limit_source ? openloop_current_limit : global_current_limit;
	assign ol_lim_rev = reverse_param_select ? reverse_openloop_current_limit : ol_lim_fwd;
	assign ramp_a1 = use_rev ? reverse_accel_linear : openloop_accel_linear;
	assign ramp_a2 = use_rev ? reverse_accel_quadratic : openloop_accel_quadratic;
	assign ilim_sum = {1'b0, current_limit_q} + {1'b0, align_ramp_rate};
	assign slow_sum = {1'b0, timer_q} + {1'b0, slow_cycle_step};

	// Control tick divider, one pulse per control period
	always_comb begin
		tick_d = (tick_cnt_q == TICK_W'(TICKS - 1));
		tick_cnt_d = tick_d ? '0 : tick_cnt_q + 1'b1;
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			tick_cnt_q <= '0;
			tick_q <= 1'b0;
		end else begin
			tick_cnt_q <= tick_cnt_d;
			tick_q <= tick_d;
		end
	end

	// Sequencer next state; gates default off so only probing drives them
	always_comb begin
		state_d = state_q;
		drive_dir_d = drive_dir_q;
		angle_d = angle_q;
		current_limit_d = current_limit_q;
		gates_d = GATES_OFF;
		timer_d = timer_q;
		pidx_d = pidx_q;
		rev_path_d = rev_path_q;
		current_loops_on_d = current_loops_on_q;
		closed_loop_d = closed_loop_q;
		ramp_load = 1'b0;
		ramp_load_val = '0;
		ramp_up = 1'b1;
		ramp_run = 1'b0;
		probe_clear = 1'b0;
		probe_rec = 1'b0;
		go_start = 1'b0;
		go_open = 1'b0;
		unique case (state_q)
			ST_IDLE: begin
				current_loops_on_d = 1'b0;
				closed_loop_d = 1'b0;
				current_limit_d = '0;
				rev_path_d = 1'b0;
				ramp_load = 1'b1;
				if (start_req && initial_speed_detect_enable) begin
					state_d = ST_WAIT_DETECT;
				end else if (start_req) begin
					go_start = 1'b1;
				end
			end
			ST_WAIT_DETECT: begin
				if (detect_done && reverse_drive_enable && detect_opposite) begin
					rev_path_d = 1'b1;
					drive_dir_d = !dir_cmd;
					current_loops_on_d = 1'b1;
					ramp_load = 1'b1;
					ramp_load_val = detect_speed;
					if (detect_speed > rev_thr) begin
						state_d = ST_REV_CL;
					end else begin
						state_d = ST_REV_OL;
						current_limit_d = ol_lim_rev;
					end
				end else if (detect_done) begin
					go_start = 1'b1;
				end
			end
			ST_REV_CL: begin
				// Speed reference locks onto the measured reverse speed
				ramp_load = 1'b1;
				ramp_load_val = est_speed;
				if (est_speed <= rev_thr) begin
					state_d = ST_REV_OL;
					current_limit_d = ol_lim_rev;
				end
			end
			ST_REV_OL: begin
				ramp_up = 1'b0;
				ramp_run = tick_q;
				if (tick_q) begin
					angle_d = adv_angle(angle_q, speed_ref_q, drive_dir_q);
				end
				if (speed_ref_q == '0) begin
					go_open = 1'b1;
				end
			end
			ST_ALIGN1, ST_ALIGN2: begin
				if (tick_q) begin
					// Ramp rather than step, to avoid a torque kick
					current_limit_d = (ilim_sum > {1'b0, align_current_limit}) ?
						align_current_limit : ilim_sum[CURR_W-1:0];
					timer_d = (timer_q == TIME_MAX) ? timer_q : timer_q + 1'b1;
				end
				if (timer_q >= align_time) begin
					if (state_q == ST_ALIGN1 && startup_method == START_DOUBLE) begin
						state_d = ST_ALIGN2;
						angle_d = angle_q + ANGLE_90;
						timer_d = '0;
						current_limit_d = '0;
					end else begin
						go_open = 1'b1;
					end
				end
			end
			ST_PROBE_DRIVE: begin
				gates_d = probe_gates(pidx_q);
				timer_d = (timer_q == TIME_MAX) ? timer_q : timer_q + 1'b1;
				if (phase_current >= probe_current_threshold) begin
					probe_rec = 1'b1;
					timer_d = '0;
					gates_d = probe_release_select ? GATES_OFF : probe_gates(pidx_q) & LOW_SIDE_MASK;
					state_d = ST_PROBE_RELEASE;
				end
			end
			ST_PROBE_RELEASE: begin
				// Recirculation relies on software leaving enough decay time
				gates_d = probe_release_select ? GATES_OFF : probe_gates(pidx_q) & LOW_SIDE_MASK;
				if (tick_q) begin
					timer_d = timer_q + 1'b1;
				end
				if (timer_q >= probe_pattern_rate && pidx_q == 3'(PROBE_LAST)) begin
					go_open = 1'b1;
				end else if (timer_q >= probe_pattern_rate) begin
					pidx_d = pidx_q + 1'b1;
					timer_d = '0;
					state_d = ST_PROBE_DRIVE;
				end
			end
			ST_SLOW: begin
				if (tick_q) begin
					timer_d = slow_sum[ANGLE_W-1:0];
					angle_d = adv_angle(angle_q, slow_cycle_step, drive_dir_q);
					if (slow_sum[ANGLE_W]) begin
						go_open = 1'b1;
					end
				end
			end
			ST_OPEN_LOOP: begin
				current_loops_on_d = 1'b1;
				ramp_run = tick_q;
				if (tick_q) begin
					angle_d = adv_angle(angle_q, speed_ref_q, drive_dir_q);
				end
				if (speed_ref_q >= handoff_speed) begin
					state_d = ST_CLOSED_LOOP;
					closed_loop_d = 1'b1;
				end
			end
			ST_CLOSED_LOOP: begin
				closed_loop_d = 1'b1;
			end
		endcase
		// Common entry to the chosen start-up method
		if (go_start) begin
			state_d = (startup_method == START_ALIGN || startup_method == START_DOUBLE) ? ST_ALIGN1 :
				(startup_method == START_PROBE) ? ST_PROBE_DRIVE : ST_SLOW;
			drive_dir_d = dir_cmd;
			angle_d = align_angle;
			current_limit_d = (startup_method == START_SLOW) ? align_current_limit : '0;
			timer_d = '0;
			pidx_d = '0;
			probe_clear = 1'b1;
			current_loops_on_d = (startup_method != START_PROBE);
		end
		// Common entry to open loop acceleration from zero speed
		if (go_open) begin
			state_d = ST_OPEN_LOOP;
			drive_dir_d = dir_cmd;
			ramp_load = 1'b1;
			current_limit_d = rev_path_q ? ol_lim_rev : ol_lim_fwd;
			current_loops_on_d = 1'b1;
			if (state_q == ST_PROBE_RELEASE) begin
				angle_d = adv_angle(probe_angle(probe_position_q), probe_drive_advance, drive_dir_q);
			end
		end
		if (stop_req) begin
			state_d = ST_IDLE;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!reset_n) begin
			state_q <= ST_IDLE;
			drive_dir_q <= 1'b0;
			angle_q <= '0;
			current_limit_q <= '0;
			gates_q <= GATES_OFF;
			timer_q <= '0;
			pidx_q <= '0;
			rev_path_q <= 1'b0;
			current_loops_on_q <= 1'b0;
			closed_loop_q <= 1'b0;
		end else begin
			state_q <= state_d;
			drive_dir_q <= drive_dir_d;
			angle_q <= angle_d;
			current_limit_q <= current_limit_d;
			gates_q <= gates_d;
			timer_q <= timer_d;
			pidx_q <= pidx_d;
			rev_path_q <= rev_path_d;
			current_loops_on_q <= current_loops_on_d;
			closed_loop_q <= closed_loop_d;
		end
	end

	// Speed profile generator
	msr_ramp #(.W(SPEED_W)) u_ramp (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.tick(ramp_run),
		.load(ramp_load),
		.load_val(ramp_load_val),
		.up(ramp_up),
		.a1(ramp_a1),
		.a2(ramp_a2),
		.dec_pct(reverse_decel_percent),
		.speed_q(speed_ref_q)
	);

	// Minimum rise time tracker
	msr_probe_min #(.TW(TIME_W)) u_probe_min (
		.clk_sys(clk_sys),
		.reset_n(reset_n),
		.clear(probe_clear),
		.rec(probe_rec),
		.idx(pidx_q),
		.rise_time(timer_q),
		.min_idx_q(probe_position_q)
	);

	chk_rev_entry: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == ST_WAIT_DETECT && detect_done && !stop_req) |=>
		((state_q == ST_REV_CL || state_q == ST_REV_OL) == $past(reverse_drive_enable && detect_opposite)))
		else $error("reverse entry does not match enable and direction");
	chk_rev_handoff: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == ST_REV_CL && est_speed <= rev_thr && !stop_req) |=> (state_q == ST_REV_OL))
		else $error("reverse open loop not entered at entry speed");
	chk_zero_cross: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == ST_REV_OL && speed_ref_q == '0 && !stop_req) |=>
		(state_q == ST_OPEN_LOOP && drive_dir_q == $past(dir_cmd)))
		else $error("no direction change at zero speed");
	chk_rev_limit: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == ST_REV_OL && $past(state_q) != ST_REV_OL && reverse_param_select)
		|-> (current_limit_q == reverse_openloop_current_limit))
		else $error("reverse open loop current limit wrong");
	chk_align_limit: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == ST_ALIGN1 && $past(state_q) != ST_ALIGN1) |->
		(current_limit_q == '0) ##1 (current_limit_q <= align_current_limit)[*2])
		else $error("align current not ramped from zero");
	chk_double_lead: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == ST_ALIGN2 && $past(state_q) == ST_ALIGN1) |-> (angle_q == $past(angle_q) + ANGLE_90))
		else $error("second align does not lead by 90 degrees");
	chk_probe_order: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == ST_PROBE_DRIVE && $past(state_q) == ST_PROBE_DRIVE) |-> (gates_q == probe_gates(pidx_q)))
		else $error("probe pattern out of order");
	chk_probe_stop: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == ST_PROBE_DRIVE && phase_current >= probe_current_threshold && !stop_req) |=>
		(state_q == ST_PROBE_RELEASE && (gates_q & ~LOW_SIDE_MASK) == GATES_OFF))
		else $error("probe drive not stopped at threshold");
	chk_release_mode: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == ST_PROBE_RELEASE && $past(state_q) == ST_PROBE_RELEASE) |->
		(gates_q == (probe_release_select ? GATES_OFF : probe_gates(pidx_q) & LOW_SIDE_MASK)))
		else $error("probe release gates wrong");
	chk_handoff: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == ST_OPEN_LOOP && speed_ref_q >= handoff_speed && !stop_req) |=> closed_loop_q)
		else $error("closed loop not entered at hand-off speed");
	chk_loops_on: assert property (@(posedge clk_sys) disable iff (!reset_n)
		(state_q == ST_OPEN_LOOP) |-> current_loops_on_q)
		else $error("current loops off in open loop");
endmodule

//--- tb/msr_motor_model.sv
/*
 Winding model for the sequencer bench: phase current rises while a high
 side switch conducts, faster on one chosen probe pattern.
 Assumes the gate word order {hs_a, ls_a, hs_b, ls_b, hs_c, ls_c}.
*/
`timescale 1ns/100ps
module msr_motor_model import msr_pkg::*; (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic reset_n,
	// Bridge and test control
	input wire logic [5:0] gates,
	input wire logic [2:0] fast_idx,
	// Sensed current
	output logic [CURR_W-1:0] phase_current
);
	logic [CURR_W-1:0] cur_d;
	logic [2:0] idx;
	// Winding pair now driven, 7 when none of the probe pairs
	always_comb begin
		case (gates)
			6'h09: idx = 3'h0;
			6'h06: idx = 3'h1;
			6'h24: idx = 3'h2;
			6'h18: idx = 3'h3;
			6'h12: idx = 3'h4;
			6'h21: idx = 3'h5;
			default: idx = 3'h7;
		endcase
	end
	// Lowest inductance pair rises four times faster; no high side means gone
	always_comb begin
		cur_d = phase_current;
		if ((gates & 6'h2A) == 6'h00)
			cur_d = '0;
		else if (phase_current < 12'h0FF0)
			cur_d = phase_current + ((idx == fast_idx) ? 12'h0004 : 12'h0001);
	end
	// Current state
	always_ff @(posedge clk_sys) begin
		phase_current <= reset_n ? cur_d : '0;
	end
endmodule

//--- tb/msr_sequencer_test.sv
/*
 Self-checking bench for the start-up and reverse sequencer.
 Assumes the winding model supplies phase current; speed is set here.
*/
`timescale 1ns/100ps
module msr_sequencer_test import msr_pkg::*; ;
	logic clk_sys = 0, reset_n = 0, start_req = 0, stop_req = 0, dir_cmd = 1;
	logic initial_speed_detect_enable = 0, detect_done = 0, detect_opposite = 0, reverse_drive_enable = 0;
	logic reverse_param_select = 1, probe_release_select = 0, openloop_limit_source = 1, auto_handoff_enable = 0;
	logic [SPEED_W-1:0] detect_speed = 0, reverse_openloop_entry_speed = 16'h0100, reverse_accel_linear = 16'h0050;
	logic [SPEED_W-1:0] reverse_accel_quadratic = 16'h0004, closed_loop_entry_speed = 16'h0200, est_speed = 0;
	logic [SPEED_W-1:0] openloop_accel_linear = 16'h0040, openloop_accel_quadratic = 16'h0002;
	logic [SPEED_W-1:0] auto_handoff_speed = 16'h0300, align_angle = 16'h1000, align_time = 16'h0003;
	logic [SPEED_W-1:0] probe_pattern_rate = 16'h0002, probe_drive_advance = 16'h4000, slow_cycle_step = 16'h2000;
	logic [CURR_W-1:0] reverse_openloop_current_limit = 12'h077, align_current_limit = 12'h010;
	logic [CURR_W-1:0] align_ramp_rate = 12'h002, probe_current_threshold = 12'h008;
	logic [CURR_W-1:0] global_current_limit = 12'h456, openloop_current_limit = 12'h123, phase_current;
	logic [7:0] reverse_decel_percent = 8'h32;
	logic [1:0] startup_method = 0;
	logic [2:0] fast_idx = 3'h3, probe_position_q;
	msr_state_type state_q;
	logic drive_dir_q, current_loops_on_q, closed_loop_q;
	logic [SPEED_W-1:0] speed_ref_q, angle_q;
	logic [CURR_W-1:0] current_limit_q;
	logic [5:0] gates_q;
	int num_errors = 0, checks_done = 0;
	msr_sequencer #(.TICKS(4)) dut (.*);
	msr_motor_model motor (.clk_sys(clk_sys), .reset_n(reset_n), .gates(gates_q), .fast_idx(fast_idx),
		.phase_current(phase_current));
	// System clock
	always #12.5 clk_sys = ~clk_sys;
	// Compare and count
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			num_errors++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// Bounded wait for a state, sampled after the edge settles
	task automatic wait_st(input msr_state_type s);
		int n;
		n = 0;
		// Look at the current cycle first so an entry value is not missed
		#1;
		while (state_q !== s && n < 3000) begin
			@(posedge clk_sys);
			#1;
			n++;
		end
		chk(16'(state_q), 16'(s));
	endtask
	task automatic pulse_start();
		@(posedge clk_sys) start_req <= 1;
		@(posedge clk_sys) start_req <= 0;
	endtask
	task automatic pulse_stop();
		@(posedge clk_sys) stop_req <= 1;
		@(posedge clk_sys) stop_req <= 0;
		#1 chk(16'(state_q), 16'(ST_IDLE));
	endtask
	// Each start-up method, in order; limit source flips between runs
	task automatic t_start(input logic [1:0] m);
		msr_state_type first [4] = '{ST_ALIGN1, ST_ALIGN1, ST_PROBE_DRIVE, ST_SLOW};
		@(posedge clk_sys) startup_method <= m;
		openloop_limit_source <= m[0];
		pulse_start();
		wait_st(first[m]);
		if (m < 2) begin
			chk(angle_q, 16'h1000);
			chk(16'(current_limit_q), 16'h0000);
		end
		if (m == 1) begin
			wait_st(ST_ALIGN2);
			chk(angle_q, 16'h5000);
			chk(16'(current_limit_q), 16'h0000);
		end
		if (m == 2) begin
			wait_st(ST_PROBE_RELEASE);
			chk(16'(gates_q), probe_release_select ? 16'h0000 : 16'h0001);
		end
		wait_st(ST_OPEN_LOOP);
		if (m == 2) chk(16'(probe_position_q), 16'h0003);
		if (m == 2) chk(angle_q, 16'hAAAB);
		if (m == 3) chk(angle_q, 16'h1000);
		chk(speed_ref_q, 16'h0000);
		chk(16'(current_limit_q), m[0] ? 16'h0123 : 16'h0456);
		chk(16'(current_loops_on_q), 16'h0001);
		// First tick gives a1 plus half of a2
		wait (speed_ref_q != 16'h0000);
		#1 chk(speed_ref_q, 16'h0041);
		pulse_stop();
	endtask
	// Opposite spin with reverse drive on or off
	task automatic t_reverse(input logic en);
		@(posedge clk_sys) initial_speed_detect_enable <= 1;
		reverse_drive_enable <= en;
		est_speed <= 16'h0180;
		pulse_start();
		wait_st(ST_WAIT_DETECT);
		@(posedge clk_sys) detect_done <= 1;
		detect_opposite <= 1;
		detect_speed <= 16'h0180;
		@(posedge clk_sys) detect_done <= 0;
		if (!en) begin
			repeat (4) @(posedge clk_sys);
			#1 chk(16'(state_q == ST_REV_CL), 16'h0000);
		end else begin
			wait_st(ST_REV_CL);
			chk(16'(drive_dir_q), 16'h0000);
			repeat (8) @(posedge clk_sys);
			#1 chk(16'(state_q), 16'(ST_REV_CL));
			@(posedge clk_sys) est_speed <= 16'h0080;
			wait_st(ST_REV_OL);
			chk(speed_ref_q, 16'h0080);
			chk(16'(current_limit_q), 16'h0077);
			// Decel step is half of the reverse linear rate
			wait (speed_ref_q != 16'h0080);
			#1 chk(speed_ref_q, 16'h0058);
			wait_st(ST_OPEN_LOOP);
			chk(16'(drive_dir_q), 16'h0001);
			wait (speed_ref_q != 16'h0000);
			#1 chk(speed_ref_q, 16'h0052);
			wait_st(ST_CLOSED_LOOP);
			chk(16'(closed_loop_q), 16'h0001);
			// Six ticks reach the manual speed, eight the automatic one
			chk(speed_ref_q, auto_handoff_enable ? 16'h0300 : 16'h0228);
		end
		pulse_stop();
		@(posedge clk_sys) initial_speed_detect_enable <= 0;
	endtask
	task automatic report_and_stop();
		$display("checks_done=%0d num_errors=%0d", checks_done, num_errors);
		if (num_errors == 0 && checks_done > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	// Main sequence
	initial begin
		repeat (3) @(posedge clk_sys);
		reset_n <= 1;
		for (int m = 0; m < 4; m++) t_start(2'(m));
		@(posedge clk_sys) probe_release_select <= 1;
		t_start(2'h2);
		t_reverse(1'b0);
		t_reverse(1'b1);
		@(posedge clk_sys) auto_handoff_enable <= 1;
		t_reverse(1'b1);
		report_and_stop();
	end
	// Hang guard, well past the expected run length
	initial begin
		#(60_000 * 25);
		num_errors++;
		report_and_stop();
	end
endmodule
